// ---- hw/tws_pkg.sv ----
package tws_pkg;

   // memory geometry
   localparam int ADDR_W = 15;
   localparam int MEM_DEPTH = 32768;

   // slave address byte layout
   localparam int SA_TYPE_LSB = 4;
   localparam int SA_SEL_LSB = 1;
   localparam int SA_RW_BIT = 0;
   // device-type code, value is arbitrary
   localparam logic [3:0] DEV_TYPE_DEF = 4'h5;

   // bit count of one byte on the wire
   localparam logic [3:0] BYTE_BITS = 4'h8;

   // serial clock made by the master
   localparam int SYS_CLK_MHZ = 250;
   localparam int SCL_PERIOD_NS = 1000;
   localparam int SCL_QTR_CYC = (SCL_PERIOD_NS * SYS_CLK_MHZ + 3999) / 4000;

   // slave states
   typedef enum logic [7:0] {
      S_IDLE = 8'h01,
      S_DADDR = 8'h02,
      S_AHI = 8'h04,
      S_ALO = 8'h08,
      S_WDATA = 8'h10,
      S_RDATA = 8'h20,
      S_ACKTX = 8'h40,
      S_ACKRX = 8'h80
   } tws_slv_state_t;

   // master states
   typedef enum logic [3:0] {
      M_IDLE = 4'h1,
      M_START = 4'h2,
      M_BYTE = 4'h4,
      M_STOP = 4'h8
   } tws_mst_state_t;

   // master commands
   typedef enum logic [1:0] {
      CMD_START = 2'h0,
      CMD_STOP = 2'h1,
      CMD_WRITE = 2'h2,
      CMD_READ = 2'h3
   } tws_cmd_t;

endpackage

// ---- hw/tws_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface tws_if;
   logic scl;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_sda_o;
   logic s_sda_oe;
   logic sda;

   // wired-and data line with pull-up
   assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

   modport dev (
      input scl,
      input sda,
      output s_sda_o,
      output s_sda_oe
   );

   modport host (
      output scl,
      output m_sda_o,
      output m_sda_oe,
      input sda
   );
endinterface
`default_nettype wire

// ---- hw/tws_mem_slave.sv ----
// What this block does
// - 32768 bytes, 15 low address bits decoded
// - master sends unused address MSB as zero; the bench sends it as one once, and the slave ignores it
// - answer only when select bits match inputs
// - write-protect high blocks all array writes
// - data line open-drain: pull low or release
// - shift out after falls, sample on rises
// - array write done before next transfer
// - slave only, never drives serial clock
// - power-on reset brings logic to idle
// - stop is data rising while clock high
// - stop aborts pending operation, goes idle
// - master ends with stop while owning data
// - start is data falling while clock high
// - start aborts and awaits new device address
// - master begins every transaction with start
// - master sends start after supply dip
// - data steady while clock high, bar conditions
// - first byte: type, select, read/write bit
// - ack after eighth bit, nack ends operation
// - address increments per byte, wraps to zero
// - protected write: no ack, address unchanged
`timescale 1ns/1ps
`default_nettype none
module tws_mem_slave #(
   parameter logic [3:0] DEV_TYPE = tws_pkg::DEV_TYPE_DEF,
   parameter int DEPTH = tws_pkg::MEM_DEPTH
) (
   // system
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   // straps
   input wire logic [2:0] i_dev_sel,
   input wire logic i_wp,
   // status
   output logic o_active,
   // two-wire bus
   tws_if.dev bus
);
   localparam int AW = tws_pkg::ADDR_W;

   if (DEPTH != (1 << AW)) begin : g_chk
      $error("tws_mem_slave: DEPTH must equal two to the address width");
   end

   typedef struct packed {
      logic [5:0] s1;
      logic [5:0] s2;
      logic scl_p;
      logic sda_p;
      tws_pkg::tws_slv_state_t st;
      tws_pkg::tws_slv_state_t nxt;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic mack;
      logic [AW-1:0] addr;
      logic sda_oe;
      logic active;
   } tws_slv_st_t;

   tws_slv_st_t q;
   tws_slv_st_t d;

   logic [7:0] mem [DEPTH];
   logic mem_we;
   logic [7:0] rd_byte;
   logic scl_s;
   logic sda_s;
   logic scl_hi;
   logic rise;
   logic fall;
   logic start;
   logic stop;
   logic match;
   logic wp_s;
   logic byte_done;

   assign scl_s = q.s2[0];
   assign sda_s = q.s2[1];
   assign wp_s = q.s2[5];
   assign scl_hi = scl_s & q.scl_p;
   assign rise = scl_s & ~q.scl_p;
   assign fall = ~scl_s & q.scl_p;
   assign start = scl_hi & q.sda_p & ~sda_s;
   assign stop = scl_hi & ~q.sda_p & sda_s;
   assign byte_done = (q.cnt == tws_pkg::BYTE_BITS);
   assign match = (q.sh[7:tws_pkg::SA_TYPE_LSB] == DEV_TYPE)
      && (q.sh[tws_pkg::SA_TYPE_LSB-1:tws_pkg::SA_SEL_LSB] == q.s2[4:2]);
   assign rd_byte = mem[q.addr];

   always_comb begin
      d = q;
      mem_we = 1'b0;
      d.s1 = {i_wp, i_dev_sel, bus.sda, bus.scl};
      d.s2 = q.s1;
      d.scl_p = q.s2[0];
      d.sda_p = q.s2[1];
      if (start) begin
         d.st = tws_pkg::S_DADDR;
         d.cnt = 4'h0;
         d.sda_oe = 1'b0;
      end else if (stop) begin
         d.st = tws_pkg::S_IDLE;
         d.cnt = 4'h0;
         d.sda_oe = 1'b0;
      end else if (rise) begin
         unique case (q.st)
            tws_pkg::S_DADDR, tws_pkg::S_AHI, tws_pkg::S_ALO, tws_pkg::S_WDATA: begin
               d.sh = {q.sh[6:0], sda_s};
               d.cnt = q.cnt + 4'h1;
            end
            tws_pkg::S_RDATA: begin
               d.cnt = q.cnt + 4'h1;
            end
            tws_pkg::S_ACKRX: begin
               d.mack = ~sda_s;
            end
            tws_pkg::S_IDLE, tws_pkg::S_ACKTX: begin
               d.cnt = q.cnt;
            end
         endcase
      end else if (fall) begin
         unique case (q.st)
            tws_pkg::S_DADDR: begin
               if (byte_done) begin
                  d.cnt = 4'h0;
                  if (match) begin
                     d.sda_oe = 1'b1;
                     d.st = tws_pkg::S_ACKTX;
                     if (q.sh[tws_pkg::SA_RW_BIT]) begin
                        d.nxt = tws_pkg::S_RDATA;
                     end else begin
                        d.nxt = tws_pkg::S_AHI;
                     end
                  end else begin
                     d.st = tws_pkg::S_IDLE;
                  end
               end
            end
            tws_pkg::S_AHI: begin
               if (byte_done) begin
                  d.cnt = 4'h0;
                  d.addr[AW-1:8] = q.sh[AW-9:0];
                  d.sda_oe = 1'b1;
                  d.st = tws_pkg::S_ACKTX;
                  d.nxt = tws_pkg::S_ALO;
               end
            end
            tws_pkg::S_ALO: begin
               if (byte_done) begin
                  d.cnt = 4'h0;
                  d.addr[7:0] = q.sh;
                  d.sda_oe = 1'b1;
                  d.st = tws_pkg::S_ACKTX;
                  d.nxt = tws_pkg::S_WDATA;
               end
            end
            tws_pkg::S_WDATA: begin
               if (byte_done) begin
                  d.cnt = 4'h0;
                  if (!wp_s) begin
                     mem_we = 1'b1;
                     d.addr = q.addr + 15'h0001;
                     d.sda_oe = 1'b1;
                     d.st = tws_pkg::S_ACKTX;
                     d.nxt = tws_pkg::S_WDATA;
                  end else begin
                     d.st = tws_pkg::S_IDLE;
                  end
               end
            end
            tws_pkg::S_ACKTX: begin
               d.sda_oe = 1'b0;
               d.st = q.nxt;
               if (q.nxt == tws_pkg::S_RDATA) begin
                  d.sh = rd_byte;
                  d.sda_oe = ~rd_byte[7];
               end
            end
            tws_pkg::S_RDATA: begin
               if (byte_done) begin
                  d.cnt = 4'h0;
                  d.sda_oe = 1'b0;
                  d.mack = 1'b0;
                  d.addr = q.addr + 15'h0001;
                  d.st = tws_pkg::S_ACKRX;
               end else begin
                  d.sh = {q.sh[6:0], 1'b0};
                  d.sda_oe = ~q.sh[6];
               end
            end
            tws_pkg::S_ACKRX: begin
               if (q.mack) begin
                  d.sh = rd_byte;
                  d.sda_oe = ~rd_byte[7];
                  d.st = tws_pkg::S_RDATA;
               end else begin
                  d.st = tws_pkg::S_IDLE;
               end
            end
            tws_pkg::S_IDLE: begin
               d.cnt = 4'h0;
            end
         endcase
      end
      d.active = (d.st != tws_pkg::S_IDLE);
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         q <= '0;
         q.st <= tws_pkg::S_IDLE;
         q.nxt <= tws_pkg::S_IDLE;
         // idle bus levels, so no false edge after reset
         q.s1 <= 6'h03;
         q.s2 <= 6'h03;
         q.scl_p <= 1'b1;
         q.sda_p <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // array write port
   always_ff @(posedge i_sys_clk) begin
      if (mem_we) begin
         mem[q.addr] <= q.sh;
      end
   end

   // outputs, clock line is never driven here
   assign bus.s_sda_o = 1'b0;
   assign bus.s_sda_oe = q.sda_oe;
   assign o_active = q.active;
endmodule
`default_nettype wire

// ---- hw/tws_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module tws_master #(
   parameter int QTR = tws_pkg::SCL_QTR_CYC
) (
   // system
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   // command
   input wire logic i_cmd_valid,
   input wire tws_pkg::tws_cmd_t i_cmd,
   input wire logic [7:0] i_cmd_data,
   input wire logic i_cmd_ack,
   output logic o_cmd_ready,
   // response
   output logic o_rsp_valid,
   output logic [7:0] o_rsp_data,
   output logic o_rsp_nack,
   // two-wire bus
   tws_if.host bus
);
   localparam int DW = $clog2(QTR + 1);

   if (QTR < 8) begin : g_chk
      $error("tws_master: QTR too short for the slave synchronisers");
   end

   typedef struct packed {
      logic s1;
      logic s2;
      logic [DW-1:0] div;
      tws_pkg::tws_mst_state_t st;
      logic [1:0] ph;
      logic [3:0] bitn;
      logic rd;
      logic rd_ack;
      logic [7:0] sh;
      logic scl;
      logic sda_oe;
      logic own;
      logic ready;
      logic rsp_v;
      logic [7:0] rsp_d;
      logic nack;
   } tws_mst_st_t;

   tws_mst_st_t q;
   tws_mst_st_t d;
   logic tick;

   assign tick = (q.div == DW'(QTR - 1));

   always_comb begin
      d = q;
      d.s1 = bus.sda;
      d.s2 = q.s1;
      d.rsp_v = 1'b0;
      d.div = tick ? '0 : q.div + 1'b1;
      unique case (q.st)
         tws_pkg::M_IDLE: begin
            d.div = '0;
            d.ph = 2'h0;
            d.ready = 1'b1;
            if (i_cmd_valid && q.ready) begin
               unique case (i_cmd)
                  tws_pkg::CMD_START: begin
                     d.st = tws_pkg::M_START;
                     d.ready = 1'b0;
                  end
                  tws_pkg::CMD_STOP: begin
                     if (q.own) begin
                        d.st = tws_pkg::M_STOP;
                        d.ready = 1'b0;
                     end
                  end
                  tws_pkg::CMD_WRITE, tws_pkg::CMD_READ: begin
                     if (q.own) begin
                        d.st = tws_pkg::M_BYTE;
                        d.ready = 1'b0;
                        d.bitn = 4'h0;
                        d.rd = (i_cmd == tws_pkg::CMD_READ);
                        d.rd_ack = i_cmd_ack;
                        d.sh = (i_cmd == tws_pkg::CMD_READ) ? 8'hFF : i_cmd_data;
                     end
                  end
               endcase
            end
         end
         tws_pkg::M_START: begin
            if (tick) begin
               d.ph = q.ph + 2'h1;
               unique case (q.ph)
                  2'h0: d.sda_oe = 1'b0;
                  2'h1: d.scl = 1'b1;
                  2'h2: d.sda_oe = 1'b1;
                  2'h3: begin
                     d.scl = 1'b0;
                     d.own = 1'b1;
                     d.st = tws_pkg::M_IDLE;
                  end
               endcase
            end
         end
         tws_pkg::M_STOP: begin
            if (tick) begin
               d.ph = q.ph + 2'h1;
               unique case (q.ph)
                  2'h0: d.sda_oe = 1'b1;
                  2'h1: d.scl = 1'b1;
                  2'h2: d.sda_oe = 1'b0;
                  2'h3: begin
                     d.own = 1'b0;
                     d.st = tws_pkg::M_IDLE;
                  end
               endcase
            end
         end
         tws_pkg::M_BYTE: begin
            if (tick) begin
               d.ph = q.ph + 2'h1;
               unique case (q.ph)
                  2'h0: begin
                     if (q.bitn < tws_pkg::BYTE_BITS) begin
                        d.sda_oe = q.rd ? 1'b0 : ~q.sh[7];
                     end else begin
                        d.sda_oe = q.rd ? q.rd_ack : 1'b0;
                     end
                  end
                  2'h1: d.scl = 1'b1;
                  2'h2: begin
                     if (q.bitn < tws_pkg::BYTE_BITS) begin
                        d.sh = {q.sh[6:0], q.s2};
                     end else begin
                        d.nack = q.rd ? ~q.rd_ack : q.s2;
                     end
                  end
                  2'h3: begin
                     d.scl = 1'b0;
                     d.bitn = q.bitn + 4'h1;
                     if (q.bitn == tws_pkg::BYTE_BITS) begin
                        d.sda_oe = 1'b0;
                        d.rsp_v = 1'b1;
                        d.rsp_d = q.sh;
                        d.st = tws_pkg::M_IDLE;
                     end
                  end
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         q <= '0;
         q.s1 <= 1'b1;
         q.s2 <= 1'b1;
         q.st <= tws_pkg::M_IDLE;
         q.scl <= 1'b1;
         q.ready <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign bus.scl = q.scl;
   assign bus.m_sda_o = 1'b0;
   assign bus.m_sda_oe = q.sda_oe;
   assign o_cmd_ready = q.ready;
   assign o_rsp_valid = q.rsp_v;
   assign o_rsp_data = q.rsp_d;
   assign o_rsp_nack = q.nack;
endmodule
`default_nettype wire

// ---- bench/tws_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module tws_asserts (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   // two-wire bus
   input wire logic i_scl,
   input wire logic i_m_sda_o,
   input wire logic i_m_sda_oe,
   input wire logic i_s_sda_o,
   input wire logic i_s_sda_oe,
   input wire logic i_sda
);
   typedef struct packed {
      logic scl;
      logic sda;
      logic first;
      logic [3:0] cnt;
      logic [7:0] byt;
   } tws_chk_t;
   tws_chk_t st_q;
   tws_chk_t st_d;
   logic start_w;
   logic stop_w;
   logic rise_w;
   assign start_w = i_scl && st_q.scl && st_q.sda && !i_sda;
   assign stop_w = i_scl && st_q.scl && !st_q.sda && i_sda;
   assign rise_w = i_scl && !st_q.scl;
   // bit count and first byte since start
   always_comb begin
      st_d = st_q;
      st_d.scl = i_scl;
      st_d.sda = i_sda;
      if (start_w) begin
         st_d.cnt = 4'h0;
         st_d.first = 1'b1;
      end else if (rise_w) begin
         if (st_q.cnt == 4'h8) begin
            st_d.cnt = 4'h0;
            st_d.first = 1'b0;
         end else begin
            st_d.cnt = st_q.cnt + 4'h1;
            st_d.byt = {st_q.byt[6:0], i_sda};
         end
      end
   end
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_q <= 15'h6000;
      end else begin
         st_q <= st_d;
      end
   end
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);
   a_slave_open_drain: assert property (i_s_sda_oe |-> !i_s_sda_o)
      else $error("slave drives data high");
   a_master_open_drain: assert property (i_m_sda_oe |-> !i_m_sda_o)
      else $error("master drives data high");
   a_steady_clk_high: assert property (i_scl && $past(i_scl) |-> $stable(i_s_sda_oe))
      else $error("slave data moved while clock high");
   a_change_after_fall: assert property ($changed(i_s_sda_oe) |-> !$past(i_scl, 3) && !i_scl)
      else $error("slave data moved outside clock low");
   a_reset_idle: assert property ($rose(i_nrst) |-> !i_s_sda_oe && !i_m_sda_oe && i_scl)
      else $error("bus not idle after reset");
   a_start_release: assert property (start_w |-> !i_s_sda_oe [*8])
      else $error("slave drives after start");
   a_stop_release: assert property (stop_w |-> !i_s_sda_oe [*8])
      else $error("slave drives after stop");
   a_addr_listen: assert property (st_q.first && st_q.cnt < 4'h8 |-> !i_s_sda_oe)
      else $error("slave drives during address byte");
   a_type_reject: assert property (rise_w && st_q.first && st_q.cnt == 4'h8
      && st_q.byt[7:4] != tws_pkg::DEV_TYPE_DEF |-> !i_s_sda_oe)
      else $error("slave acked foreign type");
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic i_sys_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic [2:0] dev_sel = 3'h0;
   logic wp = 1'b0;
   logic cmd_valid = 1'b0;
   tws_pkg::tws_cmd_t cmd = tws_pkg::CMD_START;
   logic [7:0] cmd_data = 8'h00;
   logic cmd_ack = 1'b0;
   logic cmd_ready;
   logic rsp_valid;
   logic rsp_nack;
   logic active;
   logic [7:0] rsp_data;
   logic [7:0] rd;
   logic nk;
   logic [7:0] mem_m [int];
   logic [14:0] addr_m;
   logic [14:0] base;
   int mismatches = 0;
   int tests_run = 0;
   int cycles = 0;
   int seed = 32'hfebd;

   tws_if i_tws_if ();
   tws_mem_slave i_tws_mem_slave (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_dev_sel(dev_sel),
      .i_wp(wp), .o_active(active), .bus(i_tws_if.dev));
   tws_master #(.QTR(8)) i_tws_master (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_cmd_valid(cmd_valid),
      .i_cmd(cmd), .i_cmd_data(cmd_data), .i_cmd_ack(cmd_ack), .o_cmd_ready(cmd_ready),
      .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data), .o_rsp_nack(rsp_nack), .bus(i_tws_if.host));
   tws_asserts i_tws_asserts (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_scl(i_tws_if.scl),
      .i_m_sda_o(i_tws_if.m_sda_o), .i_m_sda_oe(i_tws_if.m_sda_oe), .i_s_sda_o(i_tws_if.s_sda_o),
      .i_s_sda_oe(i_tws_if.s_sda_oe), .i_sda(i_tws_if.sda));

   always #2 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         mismatches = mismatches + 1;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [7:0] sa(input logic r);
      return {tws_pkg::DEV_TYPE_DEF, dev_sel, r};
   endfunction

   // one command, wait for ready again; a hang ends in the cycle limit
   task automatic op(input tws_pkg::tws_cmd_t c, input logic [7:0] d, input logic a);
      rd = 8'hXX;
      nk = 1'bx;
      @(negedge i_sys_clk);
      cmd_valid = 1'b1;
      cmd = c;
      cmd_data = d;
      cmd_ack = a;
      @(negedge i_sys_clk);
      cmd_valid = 1'b0;
      forever begin
         @(posedge i_sys_clk);
         #1;
         if (rsp_valid === 1'b1) begin
            rd = rsp_data;
            nk = rsp_nack;
         end
         if (cmd_ready === 1'b1) break;
      end
   endtask

   task automatic set_addr(input logic [14:0] a, input logic msb);
      op(tws_pkg::CMD_START, 8'h00, 1'b0);
      op(tws_pkg::CMD_WRITE, sa(1'b0), 1'b0);
      check({7'h00, nk}, 8'h00);
      op(tws_pkg::CMD_WRITE, {msb, a[14:8]}, 1'b0);
      check({7'h00, nk}, 8'h00);
      op(tws_pkg::CMD_WRITE, a[7:0], 1'b0);
      check({7'h00, nk}, 8'h00);
      addr_m = a;
   endtask

   task automatic wbytes(input int n);
      logic [7:0] d;
      for (int i = 0; i < n; i++) begin
         d = 8'($random(seed));
         op(tws_pkg::CMD_WRITE, d, 1'b0);
         check(rd, d);
         check({7'h00, nk}, {7'h00, wp});
         if (!wp) begin
            mem_m[addr_m] = d;
            addr_m = addr_m + 15'h0001;
         end
      end
      op(tws_pkg::CMD_STOP, 8'h00, 1'b0);
   endtask

   task automatic rbytes(input int n);
      op(tws_pkg::CMD_START, 8'h00, 1'b0);
      op(tws_pkg::CMD_WRITE, sa(1'b1), 1'b0);
      check({7'h00, nk}, 8'h00);
      for (int i = 0; i < n; i++) begin
         op(tws_pkg::CMD_READ, 8'h00, i != n - 1);
         check(rd, mem_m[addr_m]);
         check({7'h00, nk}, {7'h00, i == n - 1});
         addr_m = addr_m + 15'h0001;
      end
      op(tws_pkg::CMD_STOP, 8'h00, 1'b0);
      check({7'h00, active}, 8'h00);
   endtask

   initial begin
      repeat (3) @(negedge i_sys_clk);
      i_nrst = 1'b1;
      dev_sel = 3'($random(seed));
      base = 15'($random(seed));
      set_addr(base, 1'b1);
      wbytes(6);
      set_addr(base, 1'b0);
      rbytes(6);
      set_addr(15'h7FFF, 1'b0);
      wbytes(2);
      set_addr(15'h7FFF, 1'b0);
      rbytes(2);
      set_addr(base, 1'b0);
      op(tws_pkg::CMD_STOP, 8'h00, 1'b0);
      rbytes(1);
      @(negedge i_sys_clk);
      wp = 1'b1;
      set_addr(base, 1'b0);
      wbytes(1);
      @(negedge i_sys_clk);
      wp = 1'b0;
      rbytes(2);
      for (int s = 0; s < 9; s++) begin
         op(tws_pkg::CMD_START, 8'h00, 1'b0);
         op(tws_pkg::CMD_WRITE, (s < 8) ? {tws_pkg::DEV_TYPE_DEF, 3'(s), 1'b0}
            : {~tws_pkg::DEV_TYPE_DEF, dev_sel, 1'b0}, 1'b0);
         check({7'h00, nk}, {7'h00, s == 8 || 3'(s) != dev_sel});
         op(tws_pkg::CMD_STOP, 8'h00, 1'b0);
      end
      set_addr(base, 1'b0);
      @(negedge i_sys_clk);
      i_nrst = 1'b0;
      @(negedge i_sys_clk);
      i_nrst = 1'b1;
      check({6'h00, i_tws_if.scl, active}, 8'h02);
      set_addr(base, 1'b0);
      rbytes(1);
      report_and_stop();
   end
endmodule
`default_nettype wire
